// ==== synth_ctl_pkg.sv ====
/*
  Constants for the control and status pin logic of a clock synthesizer:
  widths, register offsets, reset values, field positions, pin indices.
  Assumes nothing of its surroundings; included by package name only.
*/
package synth_ctl_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int NUM_OUT  = 7;
  localparam int NUM_LOOP = 3;
  localparam int NUM_IN   = 3;
  localparam int NUM_PIN  = 6;
  localparam int NUM_EVT  = 7;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_OE_MASK0  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OE_MASK1  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OE_MASK2  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STEP_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STEP_SIZE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LIVE      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_OFFSET_A  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_OFFSET_C  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_OFFSET_D  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_OUT_EN    = 8'h2c;

  // ==========================================================================
  // reset values
  localparam logic [NUM_OUT-1:0]  RST_OE_MASK0  = 7'h7f;
  localparam logic [NUM_OUT-1:0]  RST_OE_MASK12 = 7'h00;
  localparam logic [NUM_LOOP-1:0] RST_STEP_MASK = 3'h0;
  localparam logic [DATA_W-1:0]   RST_STEP_SIZE = 32'h0000_0001;
  localparam logic [NUM_EVT-1:0]  RST_EVT_MASK  = 7'h00;
  localparam logic [DATA_W-1:0]   RST_OFFSET    = 32'h0000_0000;

  // ==========================================================================
  // live status fields: lock bits low, loss-of-signal bits above them
  localparam int LIVE_LOCK_LSB = 0;
  localparam int LIVE_LOS_LSB  = 3;
  // event status fields
  localparam int EVT_UNLOCK_LSB = 0;
  localparam int EVT_LOS_LSB    = 3;
  localparam int EVT_STEP_BIT   = 6;

  // ==========================================================================
  // synchronised pin indices and their idle levels
  localparam int PIN_DOWN  = 0;
  localparam int PIN_UP    = 1;
  localparam int PIN_OE0   = 2;
  localparam int PIN_OE1   = 3;
  localparam int PIN_OE2   = 4;
  localparam int PIN_RST_N = 5;
  localparam logic [NUM_PIN-1:0] PIN_IDLE = 6'h20;

endpackage : synth_ctl_pkg

// ==== pin_sync_if.sv ====
/*
  Carrier between the pin synchroniser and the control core: raw pins in,
  settled levels and one-cycle rising-edge pulses out.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none

interface pin_sync_if;

  // ==========================================================================
  // bundle
  logic [synth_ctl_pkg::NUM_PIN-1:0] raw;
  logic [synth_ctl_pkg::NUM_PIN-1:0] level;
  logic [synth_ctl_pkg::NUM_PIN-1:0] rise;

  modport sync (input raw, output level, output rise);
  modport core (output raw, input level, input rise);

endinterface : pin_sync_if

`default_nettype wire

// ==== pin_sync.sv ====
/*
  Three-stage synchroniser with agreement filter and rising-edge pulse
  for every control pin.
  Assumes pins are asynchronous levels and rst is synchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
  input  wire logic clock,
  input  wire logic rst,
  pin_sync_if.sync  pins
);

  logic [synth_ctl_pkg::NUM_PIN-1:0] s1_r;
  logic [synth_ctl_pkg::NUM_PIN-1:0] s2_r;
  logic [synth_ctl_pkg::NUM_PIN-1:0] s3_r;
  logic [synth_ctl_pkg::NUM_PIN-1:0] level_r;
  logic [synth_ctl_pkg::NUM_PIN-1:0] rise_r;

  // ==========================================================================
  // three flop chain; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= synth_ctl_pkg::PIN_IDLE;
      s2_r <= synth_ctl_pkg::PIN_IDLE;
      s3_r <= synth_ctl_pkg::PIN_IDLE;
    end else begin
      s1_r <= pins.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // settled level moves once stages two and three agree; edge pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      level_r <= synth_ctl_pkg::PIN_IDLE;
      rise_r  <= '0;
    end else begin
      for (int i = 0; i < synth_ctl_pkg::NUM_PIN; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_r[i] <= s3_r[i];
          rise_r[i]  <= s3_r[i] & ~level_r[i];  // see R13
        end else begin
          rise_r[i]  <= 1'b0;
        end
      end
    end
  end

  assign pins.level = level_r;
  assign pins.rise  = rise_r;

endmodule : pin_sync

`default_nettype wire

// ==== synth_ctl.sv ====
/*
  Control and status pin logic of a three-loop clock synthesizer: device
  reset pin, masked output enables, lock and loss-of-signal status pins,
  frequency step pins, register port and interrupt.
  Assumes loop lock and signal monitors run on the same clock; pins are
  asynchronous and pass through pin_sync.
*/
// The register offsets and strobed register access were chosen for this implementation.
// What this block does
// R1: reset pin low resets all internal logic except the pin synchroniser, which only rst resets
// R2: reset restores every register default
// R3: clock outputs disabled throughout reset
// R4: each enable pin gated by own mask
// R5: default: pin 0 all outputs, others none
// R6: unlock pin low unlocked, high locked
// R7: signal-lost pins follow status register bits
// R8: down pin lowers selected loops one step
// R9: up pin raises selected loops one step
// R10: step mask selects which loops respond
// R11: step size comes from a register
// R12: enable pins active low, high disables
// R13: step pins synchronised, edge gives one step
`timescale 1ns/10ps
`default_nettype none

module synth_ctl (
  input  wire logic                                clock,
  input  wire logic                                rst,
  // pins from the host or board
  input  wire logic                                device_reset_n,
  input  wire logic                                out_enable_pin_0_n,
  input  wire logic                                out_enable_pin_1_n,
  input  wire logic                                out_enable_pin_2_n,
  input  wire logic                                freq_step_up,
  input  wire logic                                freq_step_down,
  // loop and input monitors, same clock
  input  wire logic [synth_ctl_pkg::NUM_LOOP-1:0]  loop_locked,
  input  wire logic [synth_ctl_pkg::NUM_IN-1:0]    input_los,
  // register port
  input  wire logic [synth_ctl_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [synth_ctl_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [synth_ctl_pkg::DATA_W-1:0]    reg_rdata,
  // status pins
  output logic                                     loop_a_unlocked_n,
  output logic                                     loop_c_unlocked_n,
  output logic                                     loop_d_unlocked_n,
  output logic                                     input0_signal_lost_n,
  output logic                                     input1_signal_lost_n,
  output logic                                     input2_signal_lost_n,
  // to output drivers and loops
  output logic      [synth_ctl_pkg::NUM_OUT-1:0]   clk_out_enable,
  output logic      [synth_ctl_pkg::DATA_W-1:0]    loop_a_freq_offset,
  output logic      [synth_ctl_pkg::DATA_W-1:0]    loop_c_freq_offset,
  output logic      [synth_ctl_pkg::DATA_W-1:0]    loop_d_freq_offset,
  output logic                                     irq
);

  localparam int NL = synth_ctl_pkg::NUM_LOOP;
  localparam int NO = synth_ctl_pkg::NUM_OUT;
  localparam int NE = synth_ctl_pkg::NUM_EVT;
  localparam int DW = synth_ctl_pkg::DATA_W;

  typedef logic [DW-1:0] word_t;

  // ==========================================================================
  // helpers

  // place a narrow field in the low bits of a bus word
  function automatic word_t widen(input logic [DW-1:0] v, input int w);
    word_t m;
    m = '1;
    m = m >> (DW - w);
    return v & m;
  endfunction : widen

  // enable per output: any masked pin held high turns it off
  function automatic logic [NO-1:0] gate_outputs(
    input logic [NO-1:0] m0,
    input logic [NO-1:0] m1,
    input logic [NO-1:0] m2,
    input logic [2:0]    pin_high
  );
    logic [NO-1:0] off;
    off = ({NO{pin_high[0]}} & m0)
        | ({NO{pin_high[1]}} & m1)
        | ({NO{pin_high[2]}} & m2);
    return ~off;
  endfunction : gate_outputs

  // ==========================================================================
  // pin synchronisation
  pin_sync_if pins ();

  assign pins.raw[synth_ctl_pkg::PIN_DOWN]  = freq_step_down;
  assign pins.raw[synth_ctl_pkg::PIN_UP]    = freq_step_up;
  assign pins.raw[synth_ctl_pkg::PIN_OE0]   = out_enable_pin_0_n;
  assign pins.raw[synth_ctl_pkg::PIN_OE1]   = out_enable_pin_1_n;
  assign pins.raw[synth_ctl_pkg::PIN_OE2]   = out_enable_pin_2_n;
  assign pins.raw[synth_ctl_pkg::PIN_RST_N] = device_reset_n;

  pin_sync u_pin_sync (
    .clock (clock),
    .rst   (rst),
    .pins  (pins.sync)
  );

  // ==========================================================================
  // internal reset: port reset or settled reset pin low
  logic core_rst;

  assign core_rst = rst | ~pins.level[synth_ctl_pkg::PIN_RST_N];  // see R1

  // ==========================================================================
  // registers
  logic [NO-1:0] oe_mask0_r;
  logic [NO-1:0] oe_mask1_r;
  logic [NO-1:0] oe_mask2_r;
  logic [NL-1:0] step_mask_r;
  word_t         step_size_r;
  logic [NE-1:0] evt_mask_r;
  logic [NE-1:0] evt_stat_r;
  logic [NE-1:0] evt_stat_nxt;
  logic [NL-1:0] lock_r;
  logic [NL-1:0] los_r;
  word_t         offset_r [NL];
  word_t         rdata_r;
  logic [NO-1:0] out_en_r;
  logic          irq_r;
  logic [NL-1:0] unlocked_n_r;
  logic [NL-1:0] lost_n_r;

  logic          wr_hit;
  logic          rd_evt;

  assign wr_hit = reg_wr & ~core_rst;
  assign rd_evt = reg_rd & (reg_addr == synth_ctl_pkg::OFS_EVT_STAT);

  // software writes; any reset puts defaults back
  always_ff @(posedge clock) begin
    if (core_rst) begin  // see R2
      oe_mask0_r  <= synth_ctl_pkg::RST_OE_MASK0;  // see R5
      oe_mask1_r  <= synth_ctl_pkg::RST_OE_MASK12;  // see R5
      oe_mask2_r  <= synth_ctl_pkg::RST_OE_MASK12;
      step_mask_r <= synth_ctl_pkg::RST_STEP_MASK;
      step_size_r <= synth_ctl_pkg::RST_STEP_SIZE;
      evt_mask_r  <= synth_ctl_pkg::RST_EVT_MASK;
    end else if (wr_hit) begin
      unique case (reg_addr)
        synth_ctl_pkg::OFS_OE_MASK0:  oe_mask0_r  <= reg_wdata[NO-1:0];
        synth_ctl_pkg::OFS_OE_MASK1:  oe_mask1_r  <= reg_wdata[NO-1:0];
        synth_ctl_pkg::OFS_OE_MASK2:  oe_mask2_r  <= reg_wdata[NO-1:0];
        synth_ctl_pkg::OFS_STEP_MASK: step_mask_r <= reg_wdata[NL-1:0];
        synth_ctl_pkg::OFS_STEP_SIZE: step_size_r <= reg_wdata;  // see R11
        synth_ctl_pkg::OFS_EVT_MASK:  evt_mask_r  <= reg_wdata[NE-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // live status capture from the monitors
  always_ff @(posedge clock) begin
    if (core_rst) begin
      lock_r <= '0;
      los_r  <= '0;
    end else begin
      lock_r <= loop_locked;
      los_r  <= input_los;
    end
  end

  // ==========================================================================
  // frequency stepping of the selected loops
  logic step_up;
  logic step_dn;

  assign step_up = pins.rise[synth_ctl_pkg::PIN_UP];
  assign step_dn = pins.rise[synth_ctl_pkg::PIN_DOWN];

  // one edge, one step; both at once cancel out
  always_ff @(posedge clock) begin
    if (core_rst) begin
      for (int i = 0; i < NL; i++) begin
        offset_r[i] <= synth_ctl_pkg::RST_OFFSET;
      end
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (step_mask_r[i] && step_up && !step_dn) begin  // see R10
          offset_r[i] <= offset_r[i] + step_size_r;  // see R9
        end else if (step_mask_r[i] && step_dn && !step_up) begin
          offset_r[i] <= offset_r[i] - step_size_r;  // see R8
        end
      end
    end
  end

  // ==========================================================================
  // sticky events: loop lost lock, input lost signal, step applied
  logic [NE-1:0] evt_raw;
  logic          step_taken;

  assign step_taken = (step_up ^ step_dn) & (|step_mask_r);

  always_comb begin
    evt_raw = '0;
    evt_raw[synth_ctl_pkg::EVT_UNLOCK_LSB +: NL] = lock_r & ~loop_locked;
    evt_raw[synth_ctl_pkg::EVT_LOS_LSB +: NL]    = ~los_r & input_los;
    evt_raw[synth_ctl_pkg::EVT_STEP_BIT]         = step_taken;
  end

  // a read clears, but an event in the same cycle wins
  always_comb begin
    evt_stat_nxt = evt_stat_r;
    if (rd_evt) begin
      evt_stat_nxt = '0;
    end
    evt_stat_nxt = evt_stat_nxt | evt_raw;
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      evt_stat_r <= '0;
    end else begin
      evt_stat_r <= evt_stat_nxt;
    end
  end

  // interrupt level from unmasked sticky bits
  always_ff @(posedge clock) begin
    if (core_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_stat_nxt & evt_mask_r);
    end
  end

  // ==========================================================================
  // output clock enables
  logic [2:0] oe_high;

  assign oe_high = {pins.level[synth_ctl_pkg::PIN_OE2],
                    pins.level[synth_ctl_pkg::PIN_OE1],
                    pins.level[synth_ctl_pkg::PIN_OE0]};

  // pins are active low; masks pick what each pin controls
  always_ff @(posedge clock) begin
    if (core_rst) begin
      out_en_r <= '0;  // see R3
    end else begin
      out_en_r <= gate_outputs(oe_mask0_r, oe_mask1_r, oe_mask2_r,
                               oe_high);  // see R4, see R12
    end
  end

  // ==========================================================================
  // status pins
  always_ff @(posedge clock) begin
    if (core_rst) begin
      unlocked_n_r <= '0;
      lost_n_r     <= '1;
    end else begin
      unlocked_n_r <= lock_r;  // see R6
      lost_n_r     <= ~los_r;  // see R7
    end
  end

  // ==========================================================================
  // register read, answered the cycle after the strobe
  always_ff @(posedge clock) begin
    if (core_rst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        synth_ctl_pkg::OFS_OE_MASK0:  rdata_r <= widen(word_t'(oe_mask0_r), NO);
        synth_ctl_pkg::OFS_OE_MASK1:  rdata_r <= widen(word_t'(oe_mask1_r), NO);
        synth_ctl_pkg::OFS_OE_MASK2:  rdata_r <= widen(word_t'(oe_mask2_r), NO);
        synth_ctl_pkg::OFS_STEP_MASK: rdata_r <= widen(word_t'(step_mask_r), NL);
        synth_ctl_pkg::OFS_STEP_SIZE: rdata_r <= step_size_r;
        synth_ctl_pkg::OFS_LIVE: begin
          rdata_r <= widen(word_t'({los_r, lock_r}), 2 * NL);
        end
        synth_ctl_pkg::OFS_EVT_STAT:  rdata_r <= widen(word_t'(evt_stat_r), NE);
        synth_ctl_pkg::OFS_EVT_MASK:  rdata_r <= widen(word_t'(evt_mask_r), NE);
        synth_ctl_pkg::OFS_OFFSET_A:  rdata_r <= offset_r[0];
        synth_ctl_pkg::OFS_OFFSET_C:  rdata_r <= offset_r[1];
        synth_ctl_pkg::OFS_OFFSET_D:  rdata_r <= offset_r[2];
        synth_ctl_pkg::OFS_OUT_EN:    rdata_r <= widen(word_t'(out_en_r), NO);
        default:                      rdata_r <= '0;  // unmapped reads zero
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // ==========================================================================
  // outputs, all straight from flops
  assign reg_rdata            = rdata_r;
  assign clk_out_enable       = out_en_r;
  assign irq                  = irq_r;
  assign loop_a_unlocked_n    = unlocked_n_r[0];
  assign loop_c_unlocked_n    = unlocked_n_r[1];
  assign loop_d_unlocked_n    = unlocked_n_r[2];
  assign input0_signal_lost_n = lost_n_r[0];
  assign input1_signal_lost_n = lost_n_r[1];
  assign input2_signal_lost_n = lost_n_r[2];
  assign loop_a_freq_offset   = offset_r[0];
  assign loop_c_freq_offset   = offset_r[1];
  assign loop_d_freq_offset   = offset_r[2];

endmodule : synth_ctl

`default_nettype wire

// ==== synth_ctl_checker.sv ====
/*
  Concurrent checks on the synth_ctl top ports.
  Assumes one clock and the synchronous, active-high rst of the design.
*/
`timescale 1ns/10ps
`default_nettype none

module synth_ctl_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        device_reset_n,
  input wire logic        out_enable_pin_0_n,
  input wire logic        out_enable_pin_1_n,
  input wire logic        out_enable_pin_2_n,
  input wire logic        freq_step_up,
  input wire logic        freq_step_down,
  input wire logic [2:0]  loop_locked,
  input wire logic [2:0]  input_los,
  input wire logic [31:0] reg_rdata,
  input wire logic        loop_a_unlocked_n,
  input wire logic        loop_c_unlocked_n,
  input wire logic        loop_d_unlocked_n,
  input wire logic        input0_signal_lost_n,
  input wire logic        input1_signal_lost_n,
  input wire logic        input2_signal_lost_n,
  input wire logic [6:0]  clk_out_enable,
  input wire logic [31:0] loop_a_freq_offset,
  input wire logic [31:0] loop_c_freq_offset,
  input wire logic [31:0] loop_d_freq_offset,
  input wire logic        irq
);
  // ==========================================================================
  // saturating counts of settled cycles, so synchroniser lag is never judged
  logic [3:0] quiet_r;
  logic [3:0] devlow_r;
  logic [3:0] stepidle_r;
  logic [3:0] oelow_r;

  function automatic logic [3:0] sat(input logic [3:0] c, input logic clr);
    return clr ? 4'h0 : ((c == 4'h8) ? c : c + 4'h1);
  endfunction : sat

  // each count restarts on rst or on its own clearing condition
  always_ff @(posedge clock) begin
    quiet_r    <= sat(quiet_r, rst | ~device_reset_n);
    devlow_r   <= sat(devlow_r, rst | device_reset_n);
    stepidle_r <= sat(stepidle_r, rst | freq_step_up | freq_step_down);
    oelow_r    <= sat(oelow_r, rst | out_enable_pin_0_n |
                      out_enable_pin_1_n | out_enable_pin_2_n);
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================================
  // properties
  reset_blank_a: assert property (disable iff (1'b0)
    rst |=> clk_out_enable == 7'h00 && !irq)
    else $error("outputs on during reset");
  reset_clear_a: assert property (disable iff (1'b0)
    rst |=> loop_a_freq_offset == 32'h0 && loop_c_freq_offset == 32'h0 &&
            loop_d_freq_offset == 32'h0 && reg_rdata == 32'h0)
    else $error("state not cleared by reset");
  reset_status_a: assert property (disable iff (1'b0)
    rst |=> !loop_a_unlocked_n && !loop_c_unlocked_n && !loop_d_unlocked_n &&
            input0_signal_lost_n && input1_signal_lost_n && input2_signal_lost_n)
    else $error("status pins wrong in reset");
  pin_reset_a: assert property (
    devlow_r == 4'h8 |-> clk_out_enable == 7'h00 &&
                         loop_a_freq_offset == 32'h0)
    else $error("reset pin did not reset");
  lock_follow_a: assert property (
    quiet_r == 4'h8 |-> loop_a_unlocked_n == $past(loop_locked[0], 2) &&
                        loop_c_unlocked_n == $past(loop_locked[1], 2) &&
                        loop_d_unlocked_n == $past(loop_locked[2], 2))
    else $error("lock pins do not follow loops");
  los_follow_a: assert property (
    quiet_r == 4'h8 |-> input0_signal_lost_n == !$past(input_los[0], 2) &&
                        input1_signal_lost_n == !$past(input_los[1], 2) &&
                        input2_signal_lost_n == !$past(input_los[2], 2))
    else $error("signal lost pins do not follow status");
  step_quiet_a: assert property (
    stepidle_r == 4'h8 && quiet_r == 4'h8 |=> $stable(loop_a_freq_offset) &&
      $stable(loop_c_freq_offset) && $stable(loop_d_freq_offset))
    else $error("offset moved without a step");
  step_once_a: assert property (
    quiet_r == 4'h8 && $changed(loop_a_freq_offset) |=>
      $stable(loop_a_freq_offset) [*2])
    else $error("more than one step per edge");
  oe_all_on_a: assert property (
    oelow_r == 4'h8 && quiet_r == 4'h8 |-> clk_out_enable == 7'h7f)
    else $error("outputs off with all enable pins low");

endmodule : synth_ctl_checker

bind synth_ctl synth_ctl_checker i_chk (.*);

`default_nettype wire

// ==== pin_host.sv ====
/*
  Host or board model driving the control pins of synth_ctl.
  Assumes the bench calls its tasks; pins change just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_host (
  input  wire logic clock,
  output var logic  device_reset_n,
  output var logic  out_enable_pin_0_n,
  output var logic  out_enable_pin_1_n,
  output var logic  out_enable_pin_2_n,
  output var logic  freq_step_up,
  output var logic  freq_step_down
);
  // ==========================================================================
  // idle levels: reset released, outputs enabled, no steps
  initial begin
    {device_reset_n, out_enable_pin_0_n, out_enable_pin_1_n,
     out_enable_pin_2_n, freq_step_up, freq_step_down} = 6'h20;
  end

  // reset pin level, held until called again
  task automatic reset_pin(input logic lvl);
    @(posedge clock);
    device_reset_n <= lvl;
  endtask : reset_pin

  // enable pins, bit 0 is pin 0; high switches masked outputs off
  task automatic set_oe(input logic [2:0] lvl);
    @(posedge clock);
    {out_enable_pin_2_n, out_enable_pin_1_n, out_enable_pin_0_n} <= lvl;
  endtask : set_oe

  // one pulse, high and low long enough for the synchroniser
  task automatic step(input logic up, input logic dn, input int hi);
    @(posedge clock);
    freq_step_up   <= up;
    freq_step_down <= dn;
    repeat (hi) @(posedge clock);
    freq_step_up   <= 1'b0;
    freq_step_down <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
  endtask : step

endmodule : pin_host

`default_nettype wire

// ==== synth_ctl_tb.sv ====
/*
  Self-checking bench for synth_ctl driven through the pin_host model.
  Assumes the checker is bound to the design from its own file.
*/
`timescale 1ns/10ps
`default_nettype none

module synth_ctl_tb;
  logic        clock;
  logic        rst;
  logic [2:0]  loop_locked;
  logic [2:0]  input_los;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [6:0]  clk_out_enable;
  logic [31:0] loop_a_freq_offset, loop_c_freq_offset, loop_d_freq_offset;
  logic        irq;
  wire logic   device_reset_n, out_enable_pin_0_n, out_enable_pin_1_n;
  wire logic   out_enable_pin_2_n, freq_step_up, freq_step_down;
  logic        loop_a_unlocked_n, loop_c_unlocked_n, loop_d_unlocked_n;
  logic        input0_signal_lost_n, input1_signal_lost_n;
  logic        input2_signal_lost_n;
  int          err_total = 0;
  int          compares  = 0;

  pin_host i_host (.*);

  synth_ctl i_dut (.*);

  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // let synchroniser and output flops settle
  task automatic settle();
    repeat (10) @(posedge clock);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask : rd_chk

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("irq", 32'h1, {31'h0, irq});
    if (irq !== 1'b1) stop_test();
  endtask : wait_irq

  function automatic logic [31:0] enables();
    return {25'h0, clk_out_enable};
  endfunction : enables

  // ==========================================================================
  // scenarios
  task automatic t_defaults();
    rd_chk("oe mask0", 8'h00, 32'h7f);
    rd_chk("oe mask1", 8'h04, 32'h0);
    rd_chk("oe mask2", 8'h08, 32'h0);
    rd_chk("step mask", 8'h0c, 32'h0);
    rd_chk("step size", 8'h10, 32'h1);
    rd_chk("unmapped", 8'h40, 32'h0);
    check("enables", 32'h7f, enables());
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_oe();
    i_host.set_oe(3'b110);
    settle();
    check("enables", 32'h7f, enables());
    wr(8'h04, 32'h05);
    wr(8'h08, 32'h30);
    wr(8'h00, 32'h40);
    settle();
    check("enables", 32'h4a, enables());
    i_host.set_oe(3'b111);
    settle();
    check("enables", 32'h0a, enables());
    i_host.set_oe(3'b000);
    settle();
    check("enables", 32'h7f, enables());
    $display("test enables done");
  endtask : t_oe

  task automatic t_status();
    @(posedge clock);
    loop_locked <= 3'h5;
    input_los   <= 3'h2;
    settle();
    check("lock pins", 32'h5, {29'h0, loop_d_unlocked_n,
          loop_c_unlocked_n, loop_a_unlocked_n});
    check("los pins", 32'h5, {29'h0, input2_signal_lost_n,
          input1_signal_lost_n, input0_signal_lost_n});
    rd_chk("live", 8'h14, 32'h15);
    @(posedge clock);
    loop_locked <= 3'h7;
    input_los   <= 3'h0;
    settle();
    check("lock pins", 32'h7, {29'h0, loop_d_unlocked_n,
          loop_c_unlocked_n, loop_a_unlocked_n});
    check("los pins", 32'h7, {29'h0, input2_signal_lost_n,
          input1_signal_lost_n, input0_signal_lost_n});
    $display("test status done");
  endtask : t_status

  task automatic t_step();
    rd_chk("events", 8'h18, 32'h12);
    rd_chk("events", 8'h18, 32'h0);
    wr(8'h10, 32'h5);
    wr(8'h0c, 32'h5);
    wr(8'h1c, 32'h40);
    i_host.step(1'b1, 1'b0, 6);
    check("offset a", 32'h5, loop_a_freq_offset);
    check("offset c", 32'h0, loop_c_freq_offset);
    check("offset d", 32'h5, loop_d_freq_offset);
    wait_irq();
    rd_chk("events", 8'h18, 32'h40);
    @(posedge clock);
    #1;
    check("irq", 32'h0, {31'h0, irq});
    wr(8'h10, 32'h3);
    i_host.step(1'b0, 1'b1, 2);
    i_host.step(1'b0, 1'b1, 2);
    i_host.step(1'b1, 1'b1, 2);
    check("offset a", 32'hffff_ffff, loop_a_freq_offset);
    check("offset d", 32'hffff_ffff, loop_d_freq_offset);
    wr(8'h0c, 32'h2);
    i_host.step(1'b1, 1'b0, 2);
    check("offset c", 32'h3, loop_c_freq_offset);
    check("offset a", 32'hffff_ffff, loop_a_freq_offset);
    $display("test steps done");
  endtask : t_step

  task automatic t_reset();
    i_host.reset_pin(1'b0);
    settle();
    check("enables", 32'h0, enables());
    check("offset c", 32'h0, loop_c_freq_offset);
    wr(8'h10, 32'h9);
    i_host.reset_pin(1'b1);
    settle();
    rd_chk("oe mask0", 8'h00, 32'h7f);
    rd_chk("oe mask1", 8'h04, 32'h0);
    rd_chk("step size", 8'h10, 32'h1);
    rd_chk("step mask", 8'h0c, 32'h0);
    check("enables", 32'h7f, enables());
    $display("test device reset done");
  endtask : t_reset

  // ==========================================================================
  // clock and main sequence
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    rst         = 1'b1;
    loop_locked = 3'h7;
    input_los   = 3'h0;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    settle();
    t_defaults();
    t_oe();
    t_status();
    t_step();
    t_reset();
    stop_test();
  end

endmodule : synth_ctl_tb

`default_nettype wire
